// >>> core/event_divider.v
// Skip counter: fires once after every skip-plus-one events.
// Assumes i_event and i_clear come from logic on i_core_clk.
`default_nettype none

module event_divider #(
    parameter W = 16
) (
    input wire i_core_clk,
    input wire i_sys_rst,
    input wire i_clear,
    input wire i_event,
    input wire [W-1:0] i_skip,
    output reg o_fire
);

    reg [W-1:0] count_ff;

    // ============================================================
    // Counter
    // A clear in the same cycle as an event drops that event, so the new
    // division always starts from a known phase.
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count_ff <= {W{1'b0}};
            o_fire <= 1'b0;
        end else if (i_clear) begin
            count_ff <= {W{1'b0}};
            o_fire <= 1'b0;
        end else if (i_event) begin
            if (count_ff >= i_skip) begin
                count_ff <= {W{1'b0}};
                o_fire <= 1'b1;
            end else begin
                count_ff <= count_ff + {{(W-1){1'b0}}, 1'b1};
                o_fire <= 1'b0;
            end
        end else begin
            o_fire <= 1'b0;
        end
    end

endmodule // event_divider

`default_nettype wire

// >>> core/sync_in_out_control.v
// Synchronization control: trigger selection and qualification,
// event actions, and the programmable sync output pulse.
// Assumes a byte-wide register port driven from i_core_clk logic;
// trigger pins may be asynchronous to it.
`include "sync_ctrl_defines.vh"
`default_nettype none

module sync_in_out_control #(
    parameter SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
    input wire i_core_clk,
    input wire i_sys_rst,
    // Register port.
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [4:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    output reg o_reg_rvalid,
    // Trigger pins.
    input wire i_sync_in_primary,
    input wire i_sync_in_secondary,
    input wire i_receiver_timing_pulse,
    // Same-clock status from the rest of the unit.
    input wire i_inertial_results_ready,
    input wire i_navigation_solution_ready,
    input wire i_receiver_fix_valid,
    // Event outputs.
    output reg o_sample_start,
    output reg o_message_request,
    output reg [31:0] o_trigger_count,
    output reg o_sync_out
);

    // ============================================================
    // Decode helpers
    function [1:0] input_select;
        input [7:0] mode;
        begin
            if (mode <= `IN_MESSAGE_SECONDARY) begin
                input_select = `SEL_SECONDARY;
            end else if (mode <= `IN_MESSAGE_PRIMARY) begin
                input_select = `SEL_PRIMARY;
            end else begin
                input_select = `SEL_RECEIVER;
            end
        end
    endfunction

    function is_count_mode;
        input [7:0] mode;
        begin
            is_count_mode = (mode == `IN_COUNT_SECONDARY) ||
                            (mode == `IN_COUNT_PRIMARY) ||
                            (mode == `IN_COUNT_RECEIVER);
        end
    endfunction

    // ============================================================
    // Settings registers
    reg [7:0] trigger_input_mode_ff;
    reg [7:0] trigger_input_edge_ff;
    reg [15:0] trigger_input_divider_ff;
    reg [7:0] pulse_output_source_ff;
    reg [7:0] pulse_output_level_ff;
    reg [15:0] pulse_output_divider_ff;
    reg [31:0] pulse_output_duration_ff;
    reg in_clear_ff;
    reg out_clear_ff;

    wire wr_in_cfg;
    wire wr_out_cfg;

    assign wr_in_cfg = i_reg_wr && ((i_reg_addr == `OFS_IN_MODE) ||
                                    (i_reg_addr == `OFS_IN_DIV_LO) ||
                                    (i_reg_addr == `OFS_IN_DIV_HI));
    assign wr_out_cfg = i_reg_wr && ((i_reg_addr == `OFS_OUT_SOURCE) ||
                                     (i_reg_addr == `OFS_OUT_DIV_LO) ||
                                     (i_reg_addr == `OFS_OUT_DIV_HI));

    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            trigger_input_mode_ff <= `RST_IN_MODE;
            trigger_input_edge_ff <= `RST_IN_EDGE;
            trigger_input_divider_ff <= `RST_IN_DIV;
            pulse_output_source_ff <= `RST_OUT_SOURCE;
            pulse_output_level_ff <= `RST_OUT_LEVEL;
            pulse_output_divider_ff <= `RST_OUT_DIV;
            pulse_output_duration_ff <= `RST_OUT_DUR;
            in_clear_ff <= 1'b0;
            out_clear_ff <= 1'b0;
        end else begin
            in_clear_ff <= wr_in_cfg;
            out_clear_ff <= wr_out_cfg;
            if (i_reg_wr) begin
                // Reserved offsets fall through and are discarded.
                case (i_reg_addr)
                    `OFS_IN_MODE: trigger_input_mode_ff <= i_reg_wdata;
                    `OFS_IN_EDGE: trigger_input_edge_ff <= i_reg_wdata;
                    `OFS_IN_DIV_LO: trigger_input_divider_ff[7:0] <= i_reg_wdata;
                    `OFS_IN_DIV_HI: trigger_input_divider_ff[15:8] <= i_reg_wdata;
                    `OFS_OUT_SOURCE: pulse_output_source_ff <= i_reg_wdata;
                    `OFS_OUT_LEVEL: pulse_output_level_ff <= i_reg_wdata;
                    `OFS_OUT_DIV_LO: pulse_output_divider_ff[7:0] <= i_reg_wdata;
                    `OFS_OUT_DIV_HI: pulse_output_divider_ff[15:8] <= i_reg_wdata;
                    `OFS_OUT_DUR_B0: begin
                        pulse_output_duration_ff[7:0] <= i_reg_wdata;
                    end
                    `OFS_OUT_DUR_B1: begin
                        pulse_output_duration_ff[15:8] <= i_reg_wdata;
                    end
                    `OFS_OUT_DUR_B2: begin
                        pulse_output_duration_ff[23:16] <= i_reg_wdata;
                    end
                    `OFS_OUT_DUR_B3: begin
                        pulse_output_duration_ff[31:24] <= i_reg_wdata;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Register read
    reg [7:0] nxt_rdata;

    always @* begin
        nxt_rdata = 8'h00;
        case (i_reg_addr)
            `OFS_IN_MODE: nxt_rdata = trigger_input_mode_ff;
            `OFS_IN_EDGE: nxt_rdata = trigger_input_edge_ff;
            `OFS_IN_DIV_LO: nxt_rdata = trigger_input_divider_ff[7:0];
            `OFS_IN_DIV_HI: nxt_rdata = trigger_input_divider_ff[15:8];
            `OFS_OUT_SOURCE: nxt_rdata = pulse_output_source_ff;
            `OFS_OUT_LEVEL: nxt_rdata = pulse_output_level_ff;
            `OFS_OUT_DIV_LO: nxt_rdata = pulse_output_divider_ff[7:0];
            `OFS_OUT_DIV_HI: nxt_rdata = pulse_output_divider_ff[15:8];
            `OFS_OUT_DUR_B0: nxt_rdata = pulse_output_duration_ff[7:0];
            `OFS_OUT_DUR_B1: nxt_rdata = pulse_output_duration_ff[15:8];
            `OFS_OUT_DUR_B2: nxt_rdata = pulse_output_duration_ff[23:16];
            `OFS_OUT_DUR_B3: nxt_rdata = pulse_output_duration_ff[31:24];
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= nxt_rdata;
            end
        end
    end

    // ============================================================
    // Trigger input path
    wire [2:0] pin_level;
    wire [2:0] pin_edge;
    wire [1:0] sel;
    wire sel_edge;
    wire sync_in_event;

    trigger_sync #(
        .N(3)
    ) u_trigger_sync (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_pins({i_receiver_timing_pulse, i_sync_in_secondary, i_sync_in_primary}),
        .i_falling(trigger_input_edge_ff[0]),
        .o_level(pin_level),
        .o_edge(pin_edge)
    );

    assign sel = input_select(trigger_input_mode_ff);
    assign sel_edge = pin_edge[sel];

    event_divider #(
        .W(16)
    ) u_in_divider (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear(in_clear_ff),
        .i_event(sel_edge),
        .i_skip(trigger_input_divider_ff),
        .o_fire(sync_in_event)
    );

    // ============================================================
    // Internal sample pacing
    // The divider free-runs in every mode so a return to a counting mode
    // keeps the existing phase rather than restarting it.
    reg [31:0] pace_cnt_ff;
    reg pace_tick_ff;

    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pace_cnt_ff <= 32'h00000000;
            pace_tick_ff <= 1'b0;
        end else if (pace_cnt_ff >= SAMPLE_CYCLES - 1) begin
            pace_cnt_ff <= 32'h00000000;
            pace_tick_ff <= 1'b1;
        end else begin
            pace_cnt_ff <= pace_cnt_ff + 32'h00000001;
            pace_tick_ff <= 1'b0;
        end
    end

    // ============================================================
    // Sync-in actions
    wire sample_mode;
    wire message_mode;

    assign sample_mode = (trigger_input_mode_ff == `IN_SAMPLE_SECONDARY) ||
                         (trigger_input_mode_ff == `IN_SAMPLE_PRIMARY);
    assign message_mode = (trigger_input_mode_ff == `IN_MESSAGE_SECONDARY) ||
                          (trigger_input_mode_ff == `IN_MESSAGE_PRIMARY);

    // Externally paced sampling relies on the source holding 200 Hz; no rate
    // check is made here.
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_sample_start <= 1'b0;
            o_message_request <= 1'b0;
            o_trigger_count <= 32'h00000000;
        end else begin
            if (sample_mode) begin
                o_sample_start <= sync_in_event;
            end else begin
                o_sample_start <= pace_tick_ff;
            end
            o_message_request <= message_mode & sync_in_event;
            if (is_count_mode(trigger_input_mode_ff) && sync_in_event) begin
                o_trigger_count <= o_trigger_count + 32'h00000001;
            end
        end
    end

    // ============================================================
    // Pulse output source selection
    reg pps_prev_ff;
    reg src_event;
    wire pps_rise;
    wire out_fire;

    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pps_prev_ff <= 1'b0;
        end else begin
            pps_prev_ff <= pin_level[`SEL_RECEIVER];
        end
    end

    assign pps_rise = pin_level[`SEL_RECEIVER] & ~pps_prev_ff;

    always @* begin
        case (pulse_output_source_ff)
            `OUT_SAMPLE_START: src_event = o_sample_start;
            `OUT_INERTIAL: src_event = i_inertial_results_ready;
            `OUT_NAVIGATION: src_event = i_navigation_solution_ready;
            `OUT_RECEIVER: src_event = pps_rise & i_receiver_fix_valid;
            default: src_event = 1'b0;
        endcase
    end

    event_divider #(
        .W(16)
    ) u_out_divider (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear(out_clear_ff),
        .i_event(src_event),
        .i_skip(pulse_output_divider_ff),
        .o_fire(out_fire)
    );

    // ============================================================
    // Pulse timing
    // The remaining time is kept in nanoseconds and drops by one clock period
    // per cycle, so any width rounds up to whole cycles; zero gives one cycle.
    reg pulse_active_ff;
    reg [31:0] remain_ns_ff;

    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pulse_active_ff <= 1'b0;
            remain_ns_ff <= 32'h00000000;
        end else if (pulse_output_source_ff == `OUT_NONE) begin
            pulse_active_ff <= 1'b0;
            remain_ns_ff <= 32'h00000000;
        end else if (out_fire && !pulse_active_ff) begin
            pulse_active_ff <= 1'b1;
            remain_ns_ff <= pulse_output_duration_ff;
        end else if (pulse_active_ff) begin
            if (remain_ns_ff <= `CLK_PERIOD_NS) begin
                pulse_active_ff <= 1'b0;
                remain_ns_ff <= 32'h00000000;
            end else begin
                remain_ns_ff <= remain_ns_ff - `CLK_PERIOD_NS;
            end
        end
    end

    // ============================================================
    // Output pin
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_sync_out <= 1'b0;
        end else begin
            o_sync_out <= pulse_output_level_ff[0] ? pulse_active_ff
                                                   : ~pulse_active_ff;
        end
    end

endmodule // sync_in_out_control

`default_nettype wire

// >>> core/trigger_sync.v
// Two-stage synchronizers and edge detectors for a group of trigger pins.
// Assumes the pins are asynchronous to i_core_clk.
`default_nettype none

module trigger_sync #(
    parameter N = 3
) (
    input wire i_core_clk,
    input wire i_sys_rst,
    input wire [N-1:0] i_pins,
    input wire i_falling,
    output wire [N-1:0] o_level,
    output reg [N-1:0] o_edge
);

    reg [N-1:0] meta_ff;
    reg [N-1:0] sync_ff;
    reg [N-1:0] prev_ff;

    // ============================================================
    // Synchronizer and edge qualification
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_pin
            always @(posedge i_core_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    meta_ff[g] <= 1'b0;
                    sync_ff[g] <= 1'b0;
                    prev_ff[g] <= 1'b0;
                    o_edge[g] <= 1'b0;
                end else begin
                    meta_ff[g] <= i_pins[g];
                    sync_ff[g] <= meta_ff[g];
                    prev_ff[g] <= sync_ff[g];
                    o_edge[g] <= i_falling ? (prev_ff[g] & ~sync_ff[g])
                                           : (~prev_ff[g] & sync_ff[g]);
                end
            end
        end
    endgenerate

    assign o_level = sync_ff;

endmodule // trigger_sync

`default_nettype wire

// >>> include/sync_ctrl_defines.vh
// Constants for the synchronization control block: byte offsets, field codes,
// reset values and timing counts.
// Assumes a 200 MHz core clock and a byte-wide register port.
`ifndef SYNC_CTRL_DEFINES_VH
`define SYNC_CTRL_DEFINES_VH

// ============================================================
// Byte offsets of the settings block
`define OFS_IN_MODE        5'h00
`define OFS_IN_EDGE        5'h01
`define OFS_IN_DIV_LO      5'h02
`define OFS_IN_DIV_HI      5'h03
`define OFS_RSVD_A         5'h04
`define OFS_OUT_SOURCE     5'h08
`define OFS_OUT_LEVEL      5'h09
`define OFS_OUT_DIV_LO     5'h0a
`define OFS_OUT_DIV_HI     5'h0b
`define OFS_OUT_DUR_B0     5'h0c
`define OFS_OUT_DUR_B1     5'h0d
`define OFS_OUT_DUR_B2     5'h0e
`define OFS_OUT_DUR_B3     5'h0f
`define OFS_RSVD_B         5'h10
`define OFS_LAST           5'h13

// ============================================================
// Trigger input modes
`define IN_COUNT_SECONDARY 8'h00
`define IN_SAMPLE_SECONDARY 8'h01
`define IN_MESSAGE_SECONDARY 8'h02
`define IN_COUNT_PRIMARY   8'h03
`define IN_SAMPLE_PRIMARY  8'h04
`define IN_MESSAGE_PRIMARY 8'h05
`define IN_COUNT_RECEIVER  8'h06

// Trigger input index inside the synchronizer group
`define SEL_PRIMARY        2'h0
`define SEL_SECONDARY      2'h1
`define SEL_RECEIVER       2'h2

// ============================================================
// Pulse output sources
`define OUT_NONE           8'h00
`define OUT_SAMPLE_START   8'h01
`define OUT_INERTIAL       8'h02
`define OUT_NAVIGATION     8'h03
`define OUT_RECEIVER       8'h06

// ============================================================
// Reset values
`define RST_IN_MODE        8'h03
`define RST_IN_EDGE        8'h00
`define RST_IN_DIV         16'h0000
`define RST_OUT_SOURCE     8'h00
`define RST_OUT_LEVEL      8'h01
`define RST_OUT_DIV        16'h0000
`define RST_OUT_DUR        32'h00989680

// ============================================================
// Timing
`define CLK_PERIOD_NS      32'h00000005
`define SAMPLE_PERIOD_NS   5000000
`define CLK_PERIOD_NS_INT  5
`define SAMPLE_CYCLES      (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS_INT)

`endif

// >>> verification/sync_ctrl_asserts.sv
// Checker of the synchronization control ports.
// Assumes binding into the top module; register writes are shadowed here.
`include "sync_ctrl_defines.vh"
`default_nettype none
module sync_ctrl_chk #(parameter int SAMPLE_CYCLES = 20) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [4:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_receiver_fix_valid,
    input wire logic i_inertial_results_ready,
    input wire logic o_sample_start,
    input wire logic o_message_request,
    input wire logic [31:0] o_trigger_count,
    input wire logic o_sync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mode_ff;
    logic [7:0] src_ff;
    logic [15:0] od_ff;
    logic lvl_ff;
    wire act = (o_sync_out == lvl_ff);
    wire cnt_md = mode_ff inside {8'h00, 8'h03, 8'h06};
    wire pace_ok = (SAMPLE_CYCLES > 9);
    // ============================================================
    // Shadow of the fields the properties depend on
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_ff <= `RST_IN_MODE;
            src_ff <= `RST_OUT_SOURCE;
            od_ff <= `RST_OUT_DIV;
            lvl_ff <= 1'b1;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `OFS_IN_MODE: mode_ff <= i_reg_wdata;
                `OFS_OUT_SOURCE: src_ff <= i_reg_wdata;
                `OFS_OUT_LEVEL: lvl_ff <= i_reg_wdata[0];
                `OFS_OUT_DIV_LO: od_ff[7:0] <= i_reg_wdata;
                `OFS_OUT_DIV_HI: od_ff[15:8] <= i_reg_wdata;
                default: ;
            endcase
        end
    end
    // ============================================================
    // Properties
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    a_rsvd_zero: assert property (
        i_reg_rd && i_reg_addr inside {[5'h04:5'h07], [5'h10:5'h1f]}
        |=> o_reg_rvalid && o_reg_rdata == 8'h00) else $error("reserved byte read nonzero");
    a_count_step: assert property (
        o_trigger_count == $past(o_trigger_count) || o_trigger_count == $past(o_trigger_count) + 1)
        else $error("event counter jumped");
    a_count_mode: assert property (
        $changed(o_trigger_count) && mode_ff == $past(mode_ff, 3) |-> cnt_md)
        else $error("counter moved outside counting mode");
    a_msg_mode: assert property (
        o_message_request && mode_ff == $past(mode_ff, 3) |-> mode_ff inside {8'h02, 8'h05})
        else $error("message request outside message mode");
    a_pace_gap: assert property (
        o_sample_start && cnt_md && pace_ok && mode_ff == $past(mode_ff, 3)
        |=> !o_sample_start [*8]) else $error("internal sampling paced too fast");
    a_idle_level: assert property (
        src_ff == 8'h00 && $past(src_ff) == 8'h00 && $past(src_ff, 2) == 8'h00 && $stable(lvl_ff)
        |-> o_sync_out == !lvl_ff)
        else $error("output not idle with source off");
    a_pulse_start: assert property (
        i_inertial_results_ready && src_ff == 8'h02 && $past(src_ff) == 8'h02 && od_ff == 0
        && $stable(lvl_ff) && !act && !$past(i_inertial_results_ready)
        && !$past(i_inertial_results_ready, 2) |-> ##3 act) else $error("pulse did not start");
    a_fix_gate: assert property (
        (src_ff == 8'h06 && !i_receiver_fix_valid) [*6] ##0 ($stable(lvl_ff) && !$past(act))
        |-> !act) else $error("pulse without position fix");
    c_message: cover property (o_message_request);
    c_inertial: cover property (i_inertial_results_ready && src_ff == 8'h02 ##3 act);
    c_receiver: cover property (src_ff == 8'h06 && i_receiver_fix_valid && $rose(act));
endmodule // sync_ctrl_chk
bind sync_in_out_control sync_ctrl_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
    .i_core_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .o_reg_rvalid, .i_receiver_fix_valid, .i_inertial_results_ready, .o_sample_start,
    .o_message_request, .o_trigger_count, .o_sync_out);
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the synchronization control block.
// Assumes the shared defines header and the trigger source model.
`include "sync_ctrl_defines.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 20;
    logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [4:0] i_reg_addr = 5'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_inertial_results_ready = 1'b0, i_navigation_solution_ready = 1'b0;
    logic i_receiver_fix_valid = 1'b0, lvl = 1'b1, so_q = 1'b0;
    wire logic i_sync_in_primary, i_sync_in_secondary, i_receiver_timing_pulse, o_reg_rvalid;
    wire logic o_sample_start, o_message_request, o_sync_out;
    wire logic [7:0] o_reg_rdata;
    wire logic [31:0] o_trigger_count;
    int n_mismatch = 0, checked = 0, cyc = 0, n_smp = 0, n_msg = 0, n_pls = 0, n_act = 0, snap;
    logic [31:0] base;
    logic [159:0] dflt = {32'h0, `RST_OUT_DUR, `RST_OUT_DIV, `RST_OUT_LEVEL, `RST_OUT_SOURCE,
        32'h0, `RST_IN_DIV, `RST_IN_EDGE, `RST_IN_MODE};
    sync_in_out_control #(.SAMPLE_CYCLES(SC)) dut (
        .i_core_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .o_reg_rvalid, .i_sync_in_primary, .i_sync_in_secondary, .i_receiver_timing_pulse,
        .i_inertial_results_ready, .i_navigation_solution_ready, .i_receiver_fix_valid,
        .o_sample_start, .o_message_request, .o_trigger_count, .o_sync_out);
    trigger_source src (.o_primary(i_sync_in_primary), .o_secondary(i_sync_in_secondary),
        .o_receiver(i_receiver_timing_pulse));
    always #2.5 i_core_clk = ~i_core_clk;
    // ============================================================
    // Monitors and hang guard
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        n_smp <= n_smp + (o_sample_start === 1'b1);
        n_msg <= n_msg + (o_message_request === 1'b1);
        n_pls <= n_pls + (o_sync_out === lvl && so_q !== lvl);
        n_act <= n_act + (o_sync_out === lvl);
        so_q <= o_sync_out;
        if (cyc == 12000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_core_clk);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(negedge i_core_clk);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_core_clk);
        i_reg_rd = 1'b0;
        chk(o_reg_rvalid, 1);
        chk(o_reg_rdata, e);
    endtask
    task automatic rdy(input logic [1:0] v);
        @(negedge i_core_clk);
        {i_navigation_solution_ready, i_inertial_results_ready} = v;
        @(negedge i_core_clk);
        {i_navigation_solution_ready, i_inertial_results_ready} = 2'b00;
    endtask
    // ============================================================
    // Main sequence
    initial begin
        cycles(20);
        i_sys_rst = 1'b0;
        for (int a = 0; a < 21; a++) rd(a[4:0], a < 20 ? dflt[a*8 +: 8] : 8'h00);
        wr(`OFS_RSVD_A, 8'h5a);
        wr(`OFS_RSVD_B, 8'ha5);
        rd(`OFS_RSVD_A, 8'h00);
        rd(`OFS_RSVD_B, 8'h00);
        $display("test registers done");
        base = o_trigger_count;
        src.set_pin(0, 1'b1);
        cycles(10);
        chk(o_trigger_count, base + 1);
        wr(`OFS_IN_EDGE, 8'h01);
        src.set_pin(0, 1'b0);
        cycles(10);
        chk(o_trigger_count, base + 2);
        src.set_pin(0, 1'b1);
        cycles(10);
        chk(o_trigger_count, base + 2);
        wr(`OFS_IN_EDGE, 8'h00);
        src.set_pin(0, 1'b0);
        wr(`OFS_IN_DIV_LO, 8'h04);
        base = o_trigger_count;
        repeat (9) src.pulse(0);
        chk(o_trigger_count, base + 1);
        wr(`OFS_IN_DIV_LO, 8'h04);
        repeat (4) src.pulse(0);
        chk(o_trigger_count, base + 1);
        src.pulse(0);
        cycles(8);
        chk(o_trigger_count, base + 2);
        wr(`OFS_IN_DIV_LO, 8'h00);
        $display("test edge and divider done");
        for (int m = 0; m < 7; m++) begin
            wr(`OFS_IN_MODE, m[7:0]);
            cycles(1);
            base = o_trigger_count;
            n_smp = 0;
            n_msg = 0;
            for (int p = 0; p < 3; p++) if (p != (m < 3 ? 1 : (m < 6 ? 0 : 2))) src.pulse(p);
            src.pulse(m < 3 ? 1 : (m < 6 ? 0 : 2));
            cycles(10);
            chk(o_trigger_count - base, (m % 3 == 0) ? 1 : 0);
            chk(n_msg, (m % 3 == 2) ? 1 : 0);
            if (m % 3 == 1) chk(n_smp, 1);
            else chk(n_smp >= 2, 1);
        end
        wr(`OFS_IN_MODE, `IN_COUNT_PRIMARY);
        $display("test input modes done");
        wr(`OFS_OUT_DUR_B0, 8'h14);
        wr(`OFS_OUT_DUR_B1, 8'h00);
        wr(`OFS_OUT_DUR_B2, 8'h00);
        wr(`OFS_OUT_SOURCE, `OUT_INERTIAL);
        for (int k = 0; k < 2; k++) begin
            n_pls = 0;
            n_act = 0;
            rdy(2'b01);
            rdy(2'b10);
            cycles(12);
            chk(n_pls, 1);
            chk(n_act, 4);
            wr(`OFS_OUT_LEVEL, 8'h00);
            lvl = 1'b0;
            cycles(2);
            chk(o_sync_out, 1);
        end
        wr(`OFS_OUT_DIV_LO, 8'h02);
        n_pls = 0;
        repeat (6) begin
            rdy(2'b01);
            cycles(8);
        end
        chk(n_pls, 2);
        wr(`OFS_OUT_DIV_LO, 8'h00);
        wr(`OFS_OUT_SOURCE, `OUT_NAVIGATION);
        n_pls = 0;
        rdy(2'b10);
        rdy(2'b01);
        cycles(12);
        chk(n_pls, 1);
        wr(`OFS_OUT_SOURCE, `OUT_RECEIVER);
        n_pls = 0;
        src.pulse(2);
        chk(n_pls, 0);
        cycles(1);
        i_receiver_fix_valid = 1'b1;
        src.pulse(2);
        cycles(6);
        chk(n_pls, 1);
        wr(`OFS_OUT_SOURCE, `OUT_SAMPLE_START);
        while (o_sample_start !== 1'b1) @(negedge i_core_clk);
        cycles(5);
        n_pls = 0;
        n_smp = 0;
        cycles(60);
        snap = n_smp;
        cycles(6);
        chk(n_pls, snap);
        wr(`OFS_OUT_SOURCE, `OUT_NONE);
        n_pls = 0;
        rdy(2'b01);
        cycles(40);
        chk(n_pls, 0);
        $display("test output pulse done");
        close_out();
    end
endmodule // tb
`default_nettype wire

// >>> verification/trigger_source.sv
// Model of the external trigger equipment driving the three trigger pins.
// Assumes nothing of the core clock; edges land at odd, unrelated times.
`default_nettype none
module trigger_source (
    output wire logic o_primary,
    output wire logic o_secondary,
    output wire logic o_receiver
);
    timeunit 1ns;
    timeprecision 1ps;
    // Index 0 is the primary pin, the default trigger for new systems.
    logic [2:0] pins = 3'h0;
    assign {o_receiver, o_secondary, o_primary} = pins;
    task automatic set_pin(input int k, input logic v);
        pins[k] = v;
        #23;
    endtask
    // A source that paces sampling must hold a fixed 200 Hz event rate.
    task automatic pulse(input int k);
        #7;
        pins[k] = 1'b1;
        #41;
        pins[k] = 1'b0;
        #43;
    endtask
endmodule // trigger_source
`default_nettype wire
